// File: agcr_correct.sv
// Correction chain and output encoder for one conversion result.
// Assumes raw codes arrive as 24-bit signed values on the same clock.
`timescale 1ns/100ps
module agcr_correct import agcr_pkg::*; #(
  parameter bit HAS_DGAIN = 1'b1
) (
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire logic               clkEn,
  input  wire logic               rawValid,
  input  wire logic signed [23:0] rawCode,
  input  wire agcr_main_ctrl_t    mainCtrl,
  input  wire agcr_corr_ctrl_t    corrCtrl,
  input  wire agcr_coefs_t        coefs,
  output logic                    resultValid,
  output logic [23:0]             resultWord
);

  agcr_corr_state_t stQ;
  agcr_corr_state_t stD;

  // Coefficient of 0x400000 is unity, so full span reaches just under 2x
  function automatic logic signed [47:0] scaleBy(input logic signed [47:0] v, input logic signed [23:0] g);
    logic signed [71:0] prod;
    prod = v * 72'(g);
    return prod[COEF_FRAC +: 48];
  endfunction

  function automatic logic signed [47:0] clip(input logic signed [47:0] v, input logic signed [47:0] lo,
                                              input logic signed [47:0] hi);
    if (v > hi) return hi;
    if (v < lo) return lo;
    return v;
  endfunction

  logic signed [47:0] acc;
  logic signed [47:0] code;

  always_comb begin
    stD = stQ;
    acc = 48'(rawCode);
    if (!corrCtrl.selfOffsetDisable) begin
      acc = acc - 48'(coefs.selfOffset);
    end
    if (!corrCtrl.selfGainDisable) begin
      acc = scaleBy(acc, coefs.selfGain);
    end
    if (!corrCtrl.systemOffsetDisable) begin
      acc = acc - 48'(coefs.sysOffset);
    end
    if (!corrCtrl.systemGainDisable) begin
      acc = scaleBy(acc, coefs.sysGain);
    end
    if (mainCtrl.unipolar) begin
      acc = acc <<< 1;
    end
    // Gain applies last, to the fully corrected value
    if (HAS_DGAIN) begin
      acc = acc <<< corrCtrl.digitalGainSelect;
    end
    code = acc >>> RESULT_PAD;
    if (mainCtrl.unipolar) begin
      code = clip(code, UNI_MIN, UNI_MAX);
    end else begin
      code = clip(code, BIP_MIN, BIP_MAX);
      if (mainCtrl.format) begin
        code[19] = ~code[19];
      end
    end
    stD.valid = rawValid;
    if (rawValid) begin
      stD.word = {code[19:0], 4'h0};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stQ <= '{valid: 1'b0, word: RESULT_RST};
    end else if (clkEn) begin
      stQ <= stD;
    end
  end

  assign resultValid = stQ.valid;
  assign resultWord  = stQ.word;

endmodule

// File: agcr_host_model.sv
// Serial host model driving select, clock and data pins, mode 0.
// Assumes ref_clk is the block clock; pins move on its falling edge.
`timescale 1ns/100ps
module agcr_host_model (
  input  wire logic ref_clk,
  input  wire logic spiDout,
  output logic      spiClk,
  output logic      spiCsN,
  output logic      spiDin
);
  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiDin = 1'b0;
  end
  // Six clocks a phase: margin over the three-flop synchroniser
  task automatic hp();
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic bitx(input logic d, output logic q);
    spiDin = d;
    hp();
    q = spiDout;
    spiClk = 1'b1;
    hp();
    spiClk = 1'b0;
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [23:0] wd, input int n, output logic [23:0] rd);
    logic q;
    rd = '0;
    spiCsN = 1'b0;
    hp();
    for (int i = 7; i >= 0; i--) begin
      bitx(cmd[i], q);
    end
    for (int i = n - 1; i >= 0; i--) begin
      bitx(wd[i], q);
      rd = {rd[22:0], q};
    end
    hp();
    spiCsN = 1'b1;
    // Released line must not keep a stale level
    spiDin = ~spiDin;
    hp();
  endtask
endmodule

// File: agcr_pkg.sv
// Shared constants and types for the converter register block.
// Assumes one 20 MHz clock domain and a serial host on four pins.
package agcr_pkg;

  // Register select codes carried in the command byte
  localparam logic [4:0] REG_MAIN_CTRL   = 5'h01;
  localparam logic [4:0] REG_GPIO_CTRL   = 5'h02;
  localparam logic [4:0] REG_CORR_CTRL   = 5'h03;
  localparam logic [4:0] REG_CONV_RESULT = 5'h04;
  localparam logic [4:0] REG_SYS_OFFSET  = 5'h05;

  // Command byte layout
  localparam int CMD_START_POS = 7;
  localparam int CMD_MODE_POS  = 6;
  localparam int CMD_SEL_MSB   = 5;
  localparam int CMD_SEL_LSB   = 1;
  localparam int CMD_READ_POS  = 0;

  // Values after reset
  localparam logic [7:0]  MAIN_CTRL_RST  = 8'h02;
  localparam logic [7:0]  GPIO_CTRL_RST  = 8'h0f;
  localparam logic [7:0]  CORR_CTRL_RST  = 8'h1e;
  localparam logic [23:0] RESULT_RST     = 24'h000000;
  localparam logic [23:0] SYS_OFFSET_RST = 24'h000000;

  // Bit counts, scaling and clip limits
  localparam logic [4:0] CMD_BITS      = 5'd8;
  localparam logic [4:0] BYTE_BITS     = 5'd8;
  localparam logic [4:0] WORD_BITS     = 5'd24;
  localparam int         COEF_FRAC     = 22;
  localparam int         RESULT_PAD    = 4;
  localparam logic signed [47:0] BIP_MAX = 48'sh00000007ffff;
  localparam logic signed [47:0] BIP_MIN = -48'sh000000080000;
  localparam logic signed [47:0] UNI_MAX = 48'sh0000000fffff;
  localparam logic signed [47:0] UNI_MIN = 48'sh000000000000;

  typedef struct packed {
    logic linef;
    logic unipolar;
    logic extClk;
    logic refBuf;
    logic sigBuf;
    logic format;
    logic singleCycle;
    logic unused;
  } agcr_main_ctrl_t;

  typedef struct packed {
    logic [3:0] pinDir;
    logic [3:0] pinValueBits;
  } agcr_gpio_ctrl_t;

  typedef struct packed {
    logic [2:0] digitalGainSelect;
    logic       systemGainDisable;
    logic       systemOffsetDisable;
    logic       selfGainDisable;
    logic       selfOffsetDisable;
    logic       reserved;
  } agcr_corr_ctrl_t;

  typedef struct packed {
    logic signed [23:0] selfOffset;
    logic signed [23:0] selfGain;
    logic signed [23:0] sysOffset;
    logic signed [23:0] sysGain;
  } agcr_coefs_t;

  typedef enum {SPI_IDLE, SPI_CMD, SPI_READ, SPI_WRITE, SPI_SKIP} agcr_spi_state_t;

  typedef struct packed {
    logic        valid;
    logic [23:0] word;
  } agcr_corr_state_t;

endpackage

// File: agcr_regs.sv
// Serial register slave with pin control, correction control and result.
// Assumes the host drives clock, select and data pins slower than ref_clk/8.
//
// How it works
// - Direction zero makes the pin an input; reads return its present level.
// - Direction one drives the pin with its value bit.
// - Pin byte holds directions in bits 7..4, values in bits 3..0.
// - Digital gain select scales the corrected result; codes 100..111 give 16..128.
// - Gain select is ignored on the variant without programmable gain.
// - System gain disable set skips the system gain coefficient.
// - System offset disable set skips the system offset coefficient.
// - Self gain disable set skips the self-calibration gain coefficient.
// - Self offset disable set skips the self-calibration offset coefficient.
// - Result register is read-only; host writes leave it unchanged.
// - Result shifts out MSB first; 20-bit field sits in the top bits.
// - Unipolar results are straight binary from 0x00000 to 0xFFFFF.
// - Bipolar is offset binary with format one, two's complement with zero.
// - Two's complement spans 0x80000 through 0x00000 to 0x7FFFF.
// - Out of range results saturate at the encoding's limits.
// - System offset is a 24-bit read/write register, MSB first.
// - System offset is two's complement, kept until rewritten or recalibrated.
// - System offset is subtracted from each result when enabled.
// - System offset follows self-calibration, precedes system gain and range scaling.
// - Range bit one selects unipolar, zero selects bipolar.
`timescale 1ns/100ps
module agcr_regs import agcr_pkg::*; #(
  parameter bit HAS_DGAIN = 1'b1
) (
  input  wire logic               ref_clk,
  input  wire logic               srst,
  input  wire logic               clkEn,
  input  wire logic               spiClk,
  input  wire logic               spiCsN,
  input  wire logic               spiDin,
  output logic                    spiDout,
  output logic                    spiDoutOe,
  input  wire logic [3:0]         gpioIn,
  output logic [3:0]              gpioOut,
  output logic [3:0]              gpioOe,
  input  wire logic               rawValid,
  input  wire logic signed [23:0] rawCode,
  input  wire logic signed [23:0] selfOffsetCoef,
  input  wire logic signed [23:0] selfGainCoef,
  input  wire logic signed [23:0] sysGainCoef,
  input  wire logic               sysCalLoad,
  input  wire logic signed [23:0] sysCalOffset,
  output logic                    resultUpdated
);

  typedef struct packed {
    // Pin synchronisers and the levels they have agreed on
    logic [2:0]      clkSync;
    logic [2:0]      csSync;
    logic [2:0]      dinSync;
    logic [3:0][2:0] pinSync;
    logic            clkLvl;
    logic            csLvl;
    logic            dinLvl;
    logic [3:0]      pinLvl;
    // Serial shift machinery
    agcr_spi_state_t spiState;
    logic [7:0]      cmd;
    logic [4:0]      regSel;
    logic [4:0]      bitCnt;
    logic [23:0]     shiftOut;
    logic [23:0]     shiftIn;
    logic            dout;
    logic            doutOe;
    // Host-visible registers
    agcr_main_ctrl_t mainCtrl;
    agcr_gpio_ctrl_t gpioCtrl;
    agcr_corr_ctrl_t corrCtrl;
    logic [23:0]     result;
    logic [23:0]     sysOffset;
    logic            updated;
  } agcr_regs_state_t;

  agcr_regs_state_t stQ;
  agcr_regs_state_t stD;

  logic        corrValid;
  logic [23:0] corrWord;
  agcr_coefs_t coefs;

  // Width of each register as seen on the serial link
  function automatic logic [4:0] regBits(input logic [4:0] sel);
    case (sel)
      REG_CONV_RESULT, REG_SYS_OFFSET: return WORD_BITS;
      default:                         return BYTE_BITS;
    endcase
  endfunction

  // Change on a pin counts only once the second and third stages agree;
  // a one-clock glitch on a pin never reaches the held level
  function automatic logic settled(input logic [2:0] s, input logic held);
    if (s[1] == s[2]) begin
      return s[2];
    end
    return held;
  endfunction

  // Edge reported in the cycle its new level is first agreed
  function automatic logic edgeSeen(input logic [2:0] s, input logic held, input logic level);
    return (settled(s, held) == level) && (held != level);
  endfunction

  logic [3:0] pinLevels;
  logic       clkRise;
  logic       clkFall;
  logic       csActive;
  logic       dinLevel;
  logic [7:0] readByte;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pinLevels[i] = settled(stQ.pinSync[i], stQ.pinLvl[i]);
    end
    clkRise  = edgeSeen(stQ.clkSync, stQ.clkLvl, 1'b1);
    clkFall  = edgeSeen(stQ.clkSync, stQ.clkLvl, 1'b0);
    csActive = !settled(stQ.csSync, stQ.csLvl);
    dinLevel = settled(stQ.dinSync, stQ.dinLvl);
  end

  // Driven pins read back their value bit, the others the agreed pin level
  function automatic logic [3:0] pinReadback(input agcr_gpio_ctrl_t g, input logic [3:0] levels);
    return (g.pinDir & g.pinValueBits) | (~g.pinDir & levels);
  endfunction

  // Read value of a register, left aligned for MSB-first shifting
  function automatic logic [23:0] readWord(input logic [4:0] sel, input agcr_regs_state_t s,
                                           input logic [3:0] levels);
    logic [7:0] pins;
    pins = {s.gpioCtrl.pinDir, pinReadback(s.gpioCtrl, levels)};
    case (sel)
      REG_MAIN_CTRL:   return {s.mainCtrl, 16'h0000};
      REG_GPIO_CTRL:   return {pins, 16'h0000};
      REG_CORR_CTRL:   return {s.corrCtrl, 16'h0000};
      REG_CONV_RESULT: return s.result;
      REG_SYS_OFFSET:  return s.sysOffset;
      default:         return 24'h000000;
    endcase
  endfunction

  logic [23:0] wrWord;

  always_comb begin
    stD = stQ;
    readByte = 8'h00;
    wrWord = {stQ.shiftIn[22:0], dinLevel};
    // Three-stage synchronisers; only stages two and three are looked at
    stD.clkSync = {stQ.clkSync[1:0], spiClk};
    stD.csSync  = {stQ.csSync[1:0], spiCsN};
    stD.dinSync = {stQ.dinSync[1:0], spiDin};
    for (int i = 0; i < 4; i++) begin
      stD.pinSync[i] = {stQ.pinSync[i][1:0], gpioIn[i]};
    end
    stD.clkLvl  = settled(stQ.clkSync, stQ.clkLvl);
    stD.csLvl   = !csActive;
    stD.dinLvl  = dinLevel;
    stD.pinLvl  = pinLevels;
    stD.updated = 1'b0;

    // Select high drops the frame; a half-shifted write never commits
    if (!csActive) begin
      stD.spiState = SPI_IDLE;
      stD.doutOe   = 1'b0;
      stD.dout     = 1'b0;
    end else begin
      stD.doutOe = 1'b1;
      unique case (stQ.spiState)
        SPI_IDLE: begin
          stD.spiState = SPI_CMD;
          stD.bitCnt   = 5'd0;
          stD.dout     = 1'b0;
        end
        SPI_CMD: begin
          if (clkRise) begin
            stD.cmd    = {stQ.cmd[6:0], dinLevel};
            stD.bitCnt = stQ.bitCnt + 5'd1;
            if (stQ.bitCnt == CMD_BITS - 5'd1) begin
              stD.bitCnt = 5'd0;
              stD.regSel = stD.cmd[CMD_SEL_MSB:CMD_SEL_LSB];
              // Conversion commands belong to other logic; ignore the frame
              if (!stD.cmd[CMD_START_POS] || !stD.cmd[CMD_MODE_POS]) begin
                stD.spiState = SPI_SKIP;
              end else if (stD.cmd[CMD_READ_POS]) begin
                // Snapshot now so a new result cannot tear the read
                stD.shiftOut = readWord(stD.regSel, stQ, pinLevels);
                stD.spiState = SPI_READ;
              end else begin
                stD.spiState = SPI_WRITE;
              end
            end
          end
        end
        SPI_READ: begin
          if (clkFall) begin
            stD.dout     = stQ.shiftOut[23];
            stD.shiftOut = {stQ.shiftOut[22:0], 1'b0};
            stD.bitCnt   = stQ.bitCnt + 5'd1;
            if (stQ.bitCnt == regBits(stQ.regSel)) begin
              stD.dout     = 1'b0;
              stD.spiState = SPI_SKIP;
            end
          end
        end
        SPI_WRITE: begin
          if (clkRise) begin
            stD.shiftIn = wrWord;
            stD.bitCnt  = stQ.bitCnt + 5'd1;
            if (stQ.bitCnt == regBits(stQ.regSel) - 5'd1) begin
              readByte     = wrWord[7:0];
              stD.spiState = SPI_SKIP;
              case (stQ.regSel)
                REG_MAIN_CTRL: stD.mainCtrl = readByte;
                REG_GPIO_CTRL: stD.gpioCtrl = readByte;
                REG_CORR_CTRL: stD.corrCtrl = readByte;
                REG_SYS_OFFSET: stD.sysOffset = wrWord;
                // Result register is read-only; writes fall through
                default: stD.shiftIn = wrWord;
              endcase
            end
          end
        end
        SPI_SKIP: begin
          stD.dout = 1'b0;
        end
      endcase
    end

    // Calibration overrides a host write landing in the same cycle
    if (sysCalLoad) begin
      stD.sysOffset = sysCalOffset;
    end
    if (corrValid) begin
      stD.result  = corrWord;
      stD.updated = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // Select and clock rest at their idle levels, so reset makes no false edge
      stQ <= '{clkSync:   3'h0,
               csSync:    3'h7,
               dinSync:   3'h0,
               pinSync:   12'h000,
               clkLvl:    1'b0,
               csLvl:     1'b1,
               dinLvl:    1'b0,
               pinLvl:    4'h0,
               spiState:  SPI_IDLE,
               cmd:       8'h00,
               regSel:    5'h00,
               bitCnt:    5'h00,
               shiftOut:  24'h000000,
               shiftIn:   24'h000000,
               dout:      1'b0,
               doutOe:    1'b0,
               mainCtrl:  MAIN_CTRL_RST,
               gpioCtrl:  GPIO_CTRL_RST,
               corrCtrl:  CORR_CTRL_RST,
               result:    RESULT_RST,
               sysOffset: SYS_OFFSET_RST,
               updated:   1'b0};
    end else if (clkEn) begin
      stQ <= stD;
    end
  end

  // Only the system offset is held here; the others come from calibration logic
  always_comb begin
    coefs.selfOffset = selfOffsetCoef;
    coefs.selfGain   = selfGainCoef;
    coefs.sysOffset  = stQ.sysOffset;
    coefs.sysGain    = sysGainCoef;
  end

  agcr_correct #(
    .HAS_DGAIN(HAS_DGAIN)
  ) uCorrect (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .clkEn      (clkEn),
    .rawValid   (rawValid),
    .rawCode    (rawCode),
    .mainCtrl   (stQ.mainCtrl),
    .corrCtrl   (stQ.corrCtrl),
    .coefs      (coefs),
    .resultValid(corrValid),
    .resultWord (corrWord)
  );

  assign spiDout       = stQ.dout;
  assign spiDoutOe     = stQ.doutOe;
  assign gpioOut       = stQ.gpioCtrl.pinValueBits;
  // Direction bit doubles as the pin's output enable
  assign gpioOe        = stQ.gpioCtrl.pinDir;
  assign resultUpdated = stQ.updated;

endmodule

// File: agcr_regs_chk.sv
// Port checker for the converter register block.
// Assumes clkEn is held high by the bench.
`timescale 1ns/100ps
module agcr_regs_chk import agcr_pkg::*; (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic       spiCsN,
  input wire logic       spiDout,
  input wire logic       spiDoutOe,
  input wire logic [3:0] gpioOut,
  input wire logic [3:0] gpioOe,
  input wire logic       rawValid,
  input wire logic       resultUpdated
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  AST_RST_PINS: assert property ($fell(srst) |-> gpioOe == 4'h0 && gpioOut == 4'hf)
    else $error("pins not released after reset");
  AST_OE_ON: assert property ((!spiCsN) [*6] |-> spiDoutOe)
    else $error("data out not enabled in frame");
  AST_OE_OFF: assert property (spiCsN [*6] |-> !spiDoutOe)
    else $error("data out enabled outside frame");
  AST_DOUT_REL: assert property (!spiDoutOe |-> !spiDout)
    else $error("data out high while released");
  AST_UPD_LAT: assert property (rawValid |-> ##2 resultUpdated)
    else $error("result update late");
  AST_UPD_SRC: assert property (resultUpdated |-> $past(rawValid, 2))
    else $error("result update without conversion");
  AST_UPD_PULSE: assert property (resultUpdated |=> !resultUpdated)
    else $error("result update too long");
  AST_PIN_FRAME: assert property (($changed(gpioOe) || $changed(gpioOut)) |-> !$past(spiCsN, 2))
    else $error("pin control changed outside a frame");
  // Main traffic seen at least once
  cover property (resultUpdated);
  cover property ($rose(spiDoutOe));
  cover property ($changed(gpioOe));
endmodule

// File: tb_agcr_regs.sv
// Self-checking bench for the register block with a serial host model.
// Assumes package, block, host model and checker compiled before it.
`timescale 1ns/100ps
module tb_agcr_regs import agcr_pkg::*;;
  logic               ref_clk = 1'b0;
  logic               srst = 1'b1;
  logic               spiClk, spiCsN, spiDin, spiDout, spiDoutOe, resultUpdated;
  logic               rawValid = 1'b0;
  logic               sysCalLoad = 1'b0;
  logic [3:0]         gpioIn = 4'h0;
  logic [3:0]         gpioOut, gpioOe;
  logic signed [23:0] rawCode = 24'sh000000;
  logic signed [23:0] selfOffsetCoef = 24'sh000000;
  logic signed [23:0] sysCalOffset = 24'sh000000;
  logic signed [23:0] selfGainCoef = 24'sh400000;
  logic signed [23:0] sysGainCoef = 24'sh400000;
  logic signed [23:0] so;
  logic [23:0]        rd, last;
  logic [7:0]         w;
  logic signed [23:0] cor [4] = '{24'sh7fffff, 24'sh800000, 24'sh000000, 24'sh400000};
  int                 errors = 0;
  int                 cmp_count = 0;
  int                 cyc = 0;
  int                 seed = 32'h0e42;
  int                 r;

  agcr_regs agcr_regs_inst (.ref_clk(ref_clk), .srst(srst), .clkEn(1'b1), .spiClk(spiClk), .spiCsN(spiCsN),
    .spiDin(spiDin), .spiDout(spiDout), .spiDoutOe(spiDoutOe), .gpioIn(gpioIn), .gpioOut(gpioOut),
    .gpioOe(gpioOe), .rawValid(rawValid), .rawCode(rawCode), .selfOffsetCoef(selfOffsetCoef),
    .selfGainCoef(selfGainCoef), .sysGainCoef(sysGainCoef), .sysCalLoad(sysCalLoad),
    .sysCalOffset(sysCalOffset), .resultUpdated(resultUpdated));
  agcr_host_model agcr_host_model_inst (.ref_clk(ref_clk), .spiDout(spiDout), .spiClk(spiClk),
    .spiCsN(spiCsN), .spiDin(spiDin));

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Longest legal run is about 23k cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic [4:0] sel, input logic rdn, input logic [23:0] wd, input int n);
    agcr_host_model_inst.frame({2'b11, sel, rdn}, wd, n, rd);
  endtask
  task automatic rchk(input logic [4:0] sel, input int n, input logic [23:0] e, input string nm);
    acc(sel, 1'b1, 24'h0, n);
    chk(nm, e, rd);
  endtask

  function automatic logic [23:0] expv(input logic signed [23:0] raw, input logic [7:0] m, input logic [7:0] c,
                                       input logic signed [23:0] sOff, input logic signed [23:0] cOff,
                                       input logic signed [23:0] cGain, input logic signed [23:0] sGain);
    longint v, lo, hi;
    v = raw;
    if (!c[1]) v -= cOff;
    if (!c[2]) v = (v * cGain) >>> COEF_FRAC;
    if (!c[3]) v -= sOff;
    if (!c[4]) v = (v * sGain) >>> COEF_FRAC;
    if (m[6]) v *= 2;
    v = (v <<< c[7:5]) >>> 4;
    lo = m[6] ? 64'sh0 : -64'sh80000;
    hi = m[6] ? 64'shfffff : 64'sh7ffff;
    if (v < lo) v = lo;
    if (v > hi) v = hi;
    if (!m[6] && m[2]) v ^= 64'sh80000;
    return {v[19:0], 4'h0};
  endfunction

  task automatic conv(input logic signed [23:0] raw, input logic [7:0] m, input logic [7:0] c);
    logic [23:0] want;
    acc(REG_MAIN_CTRL, 1'b0, {16'h0, m}, 8);
    acc(REG_CORR_CTRL, 1'b0, {16'h0, c}, 8);
    @(negedge ref_clk);
    rawCode = raw;
    rawValid = 1'b1;
    @(negedge ref_clk);
    rawValid = 1'b0;
    want = expv(raw, m, c, so, selfOffsetCoef, selfGainCoef, sysGainCoef);
    rchk(REG_CONV_RESULT, 24, want, "result");
  endtask

  initial begin
    so = 24'sh0;
    repeat (5) @(negedge ref_clk);
    srst = 1'b0;
    gpioIn = 4'h9;
    repeat (6) @(negedge ref_clk);
    rchk(REG_GPIO_CTRL, 8, 24'h09, "gpio_rst");
    rchk(REG_CORR_CTRL, 8, 24'h1e, "corr_rst");
    rchk(REG_MAIN_CTRL, 8, 24'h02, "main_rst");
    rchk(REG_CONV_RESULT, 24, 24'h0, "result_rst");
    rchk(REG_SYS_OFFSET, 24, 24'h0, "soc_rst");
    rchk(5'h1f, 8, 24'h0, "unmapped");
    for (int i = 0; i < 5; i++) begin
      w = (i == 0) ? 8'ha5 : 8'($random(seed));
      gpioIn = 4'($random(seed));
      acc(REG_GPIO_CTRL, 1'b0, {16'h0, w}, 8);
      chk("gpio_pins", {16'h0, w}, {16'h0, gpioOe, gpioOut});
      rchk(REG_GPIO_CTRL, 8, {16'h0, w[7:4], (w[3:0] & w[7:4]) | (gpioIn & ~w[7:4])}, "gpio_read");
    end
    for (int d = 0; d < 8; d++) begin
      conv(24'($random(seed)), {1'b0, d % 3 == 2, 3'b0, d % 3 == 1, 2'b10}, {3'(d), 5'b11110});
    end
    for (int k = 0; k < 8; k++) begin
      conv(cor[k % 4], (k < 4) ? 8'h06 : 8'h42, (k % 2 == 1) ? 8'hfe : 8'h1e);
    end
    last = rd;
    acc(REG_CONV_RESULT, 1'b0, ~last, 24);
    rchk(REG_CONV_RESULT, 24, last, "result_ro");
    r = $random(seed);
    so = {{4{r[19]}}, r[19:0]};
    acc(REG_SYS_OFFSET, 1'b0, so, 24);
    rchk(REG_SYS_OFFSET, 24, so, "soc_rw");
    r = $random(seed);
    selfOffsetCoef = {{6{r[17]}}, r[17:0]};
    conv(24'sh300000, 8'h42, 8'h14);
    conv(24'sh300000, 8'h42, 8'h1c);
    conv(-24'sh100000, 8'h02, 8'h14);
    selfGainCoef = 24'sh300000;
    sysGainCoef = 24'sh500000;
    conv(24'sh200000, 8'h42, 8'h00);
    conv(-24'sh180000, 8'h06, 8'h08);
    @(negedge ref_clk);
    sysCalOffset = 24'sh0abcde;
    sysCalLoad = 1'b1;
    @(negedge ref_clk);
    sysCalLoad = 1'b0;
    rchk(REG_SYS_OFFSET, 24, 24'h0abcde, "soc_cal");
    results();
  end
endmodule

bind agcr_regs agcr_regs_chk agcr_regs_chk_inst (.ref_clk(ref_clk), .srst(srst), .spiCsN(spiCsN),
  .spiDout(spiDout), .spiDoutOe(spiDoutOe), .gpioOut(gpioOut), .gpioOe(gpioOe), .rawValid(rawValid),
  .resultUpdated(resultUpdated));
